// file: acq_timing_pkg.sv
// Purpose: Shared constants for the acquisition sample timing engine
// Assumes: Register port with word indices, 32-bit data
// Notes:   Widths of counters are set by the engine's CNT_W parameter
package acq_timing_pkg;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_POST = 4'h2;
    localparam logic [3:0] REG_PRE = 4'h3;
    localparam logic [3:0] REG_DIV = 4'h4;
    localparam logic [3:0] REG_DELAY = 4'h5;
    localparam logic [3:0] REG_SRC = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'h9;
    localparam logic [3:0] REG_COUNT = 4'ha;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_W = 13;
    localparam int C_PRETRIG = 0;
    localparam int C_CONT = 1;
    localparam int C_BEGIN_SW = 2;
    localparam int C_STROBE_FALL = 3;
    localparam int C_TB_FALL = 4;
    localparam int C_STRB_SRC_LSB = 5;
    localparam int C_PIN_OUT = 7;
    localparam int C_TB_EXT = 8;
    localparam int C_BEGIN_FALL = 9;
    localparam int C_REF_FALL = 10;
    localparam int C_REF_EN = 11;
    localparam int C_BEGIN_OUT = 12;
    localparam logic [12:0] CTRL_RST = 13'h0004;

    // Strobe source codes
    localparam logic [1:0] STRB_DIV = 2'h0;
    localparam logic [1:0] STRB_LINE = 2'h1;
    localparam logic [1:0] STRB_TB = 2'h2;

    // Command bits
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;

    // ------------------------------------------------------------------
    // Line select fields
    // ------------------------------------------------------------------
    localparam int SRC_FLD_W = 5;
    localparam int SRC_W = 20;
    localparam int SRC_STROBE_LSB = 0;
    localparam int SRC_BEGIN_LSB = 5;
    localparam int SRC_REF_LSB = 10;
    localparam int SRC_TB_LSB = 15;
    localparam logic [19:0] SRC_RST = 20'h00000;
    localparam int MAX_LINES = 32;

    // ------------------------------------------------------------------
    // Interrupt bits and reset values
    // ------------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REF_OK = 1;
    localparam int IRQ_REF_IGN = 2;
    localparam logic [31:0] DIV_RST = 32'h00000002;
    localparam logic [31:0] DELAY_RST = 32'h00000002;
    localparam logic [31:0] COUNT_RST = 32'h00000000;

endpackage

// file: line_edge_detect.sv
// Purpose: Edge pulse per line with selectable active edge
// Assumes: Inputs synchronous to clk_sys
// Notes:   Pulse is combinational from the stored previous level
`timescale 1ns/10ps
module line_edge_detect #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Lines
    input wire logic [W-1:0] sig,
    input wire logic [W-1:0] fall,
    output logic [W-1:0] pulse
);
    typedef struct packed {
        logic [W-1:0] prev;
    } edge_state_t;

    edge_state_t s;
    edge_state_t n;

    always_comb begin
        n = s;
        n.prev = sig;
    end

    // ------------------------------------------------------------------
    // Edge per line
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign pulse[i] = fall[i] ? (s.prev[i] & ~sig[i])
                                  : (~s.prev[i] & sig[i]);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule // line_edge_detect

// file: acq_timing.sv
// Purpose: Sample strobe and trigger timing engine for acquisition
// Assumes: All line inputs synchronous to clk_sys (25 MHz)
// Notes:   Registers reached by word index on a plain port
`timescale 1ns/10ps
module acq_timing #(
    parameter int N_PFI = 10,
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [acq_timing_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [acq_timing_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [acq_timing_pkg::DATA_W-1:0] reg_rdata,
    // Trigger and clock lines
    input wire logic [N_PFI-1:0] programmable_function_line,
    input wire logic [6:0] bus_trigger_line,
    // Sample strobe pin
    input wire logic strobe_out_pin_i,
    output logic strobe_out_pin_o,
    output logic strobe_out_pin_oe,
    // Start trigger output line
    output logic begin_trigger_out_line,
    output logic begin_trigger_out_oe,
    // Front end and buffer
    output logic acq_capture,
    output logic [CNT_W-1:0] buf_wr_addr,
    output logic buf_overwrite,
    // Interrupt
    output logic irq
);
    localparam int NL = N_PFI + 8;

    if (N_PFI < 1 || NL > acq_timing_pkg::MAX_LINES || CNT_W < 2 ||
        CNT_W > acq_timing_pkg::DATA_W) begin : g_bad_param
        $error("acq_timing: N_PFI or CNT_W out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE,
        ST_WAIT_REF,
        ST_POST,
        ST_CONT
    } phase_t;

    typedef struct packed {
        phase_t state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] div_cnt;
        logic [acq_timing_pkg::CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] post;
        logic [CNT_W-1:0] pre;
        logic [CNT_W-1:0] div;
        logic [CNT_W-1:0] dly;
        logic [acq_timing_pkg::SRC_W-1:0] src;
        logic [acq_timing_pkg::IRQ_W-1:0] stat;
        logic [acq_timing_pkg::IRQ_W-1:0] mask;
        logic [CNT_W-1:0] wr_ptr;
        logic buf_full;
        logic overwrite;
        logic capture;
        logic pin_o;
        logic begin_out;
        logic irq;
        logic [acq_timing_pkg::DATA_W-1:0] rd_data;
    } eng_state_t;

    eng_state_t s;
    eng_state_t n;

    // ------------------------------------------------------------------
    // Line selection and edge detection
    // ------------------------------------------------------------------
    logic [NL-1:0] lines;
    logic [acq_timing_pkg::MAX_LINES-1:0] lines_ext;
    logic [3:0] sel_sig;
    logic [3:0] sel_fall;
    logic [3:0] edg;

    assign lines = {strobe_out_pin_i, bus_trigger_line,
                    programmable_function_line};
    assign lines_ext = acq_timing_pkg::MAX_LINES'(lines);

    // Any function line or bus trigger line may feed each input
    assign sel_sig[0] = lines_ext[s.src[acq_timing_pkg::SRC_TB_LSB +:
                                        acq_timing_pkg::SRC_FLD_W]];
    assign sel_sig[1] = lines_ext[s.src[acq_timing_pkg::SRC_BEGIN_LSB +:
                                        acq_timing_pkg::SRC_FLD_W]];
    assign sel_sig[2] = lines_ext[s.src[acq_timing_pkg::SRC_REF_LSB +:
                                        acq_timing_pkg::SRC_FLD_W]];
    assign sel_sig[3] = lines_ext[s.src[acq_timing_pkg::SRC_STROBE_LSB +:
                                        acq_timing_pkg::SRC_FLD_W]];
    assign sel_fall[0] = s.ctrl[acq_timing_pkg::C_TB_FALL];
    assign sel_fall[1] = s.ctrl[acq_timing_pkg::C_BEGIN_FALL];
    assign sel_fall[2] = s.ctrl[acq_timing_pkg::C_REF_FALL];
    assign sel_fall[3] = s.ctrl[acq_timing_pkg::C_STROBE_FALL];

    line_edge_detect #(
        .W(4)
    ) u_edge (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .sig(sel_sig),
        .fall(sel_fall),
        .pulse(edg)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic tb_tick;
    logic sw_start;
    logic sw_stop;
    logic start;
    logic ref_evt;
    logic active;
    logic div_strobe;
    logic strobe;
    logic [CNT_W-1:0] buf_size;
    logic [acq_timing_pkg::IRQ_W-1:0] ev;

    always_comb begin
        n = s;
        n.capture = 1'b0;
        n.pin_o = 1'b0;
        n.begin_out = 1'b0;
        n.overwrite = 1'b0;
        n.rd_data = '0;
        ev = '0;
        div_strobe = 1'b0;
        tb_tick = s.ctrl[acq_timing_pkg::C_TB_EXT] ? edg[0] : 1'b1;
        sw_start = reg_wr && reg_addr == acq_timing_pkg::REG_CMD &&
                   reg_wdata[acq_timing_pkg::CMD_START];
        sw_stop = reg_wr && reg_addr == acq_timing_pkg::REG_CMD &&
                  reg_wdata[acq_timing_pkg::CMD_STOP];
        start = (s.state == ST_IDLE) &&
                (s.ctrl[acq_timing_pkg::C_BEGIN_SW] ? sw_start
                                                     : edg[1]);
        ref_evt = edg[2] && s.ctrl[acq_timing_pkg::C_REF_EN];
        active = (s.state != ST_IDLE);
        buf_size = s.ctrl[acq_timing_pkg::C_PRETRIG] ? s.pre + s.post
                                                       : s.post;

        // Divider runs only while acquiring
        if (active && tb_tick) begin
            if (s.div_cnt <= CNT_W'(1)) begin
                div_strobe = 1'b1;
                n.div_cnt = s.div;
            end else begin
                n.div_cnt = s.div_cnt - CNT_W'(1);
            end
        end

        case (s.ctrl[acq_timing_pkg::C_STRB_SRC_LSB +: 2])
            acq_timing_pkg::STRB_DIV: strobe = active && div_strobe;
            acq_timing_pkg::STRB_LINE: strobe = active && edg[3];
            acq_timing_pkg::STRB_TB: strobe = active && tb_tick;
            default: strobe = 1'b0;
        endcase

        // One capture and one pin pulse per strobe
        if (strobe) begin
            n.capture = 1'b1;
            n.pin_o = 1'b1;
            if (s.wr_ptr >= buf_size - CNT_W'(1)) begin
                n.wr_ptr = '0;
                n.buf_full = 1'b1;
            end else begin
                n.wr_ptr = s.wr_ptr + CNT_W'(1);
            end
            n.overwrite = s.buf_full && (s.state == ST_PRE ||
                                         s.state == ST_WAIT_REF);
        end

        case (s.state)
            ST_IDLE: begin
                if (start) begin
                    n.begin_out = s.ctrl[acq_timing_pkg::C_BEGIN_SW];
                    n.wr_ptr = '0;
                    n.buf_full = 1'b0;
                    n.div_cnt = (s.dly == '0) ? CNT_W'(1) : s.dly;
                    if (s.ctrl[acq_timing_pkg::C_CONT]) begin
                        n.state = ST_CONT;
                        n.cnt = '0;
                    end else if (s.ctrl[acq_timing_pkg::C_PRETRIG]) begin
                        n.state = ST_PRE;
                        n.cnt = s.pre;
                    end else begin
                        n.state = ST_POST;
                        n.cnt = s.post;
                    end
                end
            end
            ST_PRE: begin
                if (ref_evt) begin
                    ev[acq_timing_pkg::IRQ_REF_IGN] = 1'b1;
                end
                if (strobe) begin
                    if (s.cnt <= CNT_W'(1)) begin
                        n.state = ST_WAIT_REF;
                        n.cnt = s.post;
                    end else begin
                        n.cnt = s.cnt - CNT_W'(1);
                    end
                end
            end
            ST_WAIT_REF: begin
                if (ref_evt) begin
                    n.state = ST_POST;
                    ev[acq_timing_pkg::IRQ_REF_OK] = 1'b1;
                end
            end
            ST_POST: begin
                if (strobe) begin
                    if (s.cnt <= CNT_W'(1)) begin
                        n.state = ST_IDLE;
                        n.cnt = '0;
                        ev[acq_timing_pkg::IRQ_DONE] = 1'b1;
                    end else begin
                        n.cnt = s.cnt - CNT_W'(1);
                    end
                end
            end
            ST_CONT: begin
                n.cnt = s.cnt;
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        if (sw_stop && active) begin
            n.state = ST_IDLE;
            n.cnt = '0;
        end

        // ------------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------------
        if (reg_wr) begin
            case (reg_addr)
                acq_timing_pkg::REG_CTRL:
                    n.ctrl = reg_wdata[acq_timing_pkg::CTRL_W-1:0];
                acq_timing_pkg::REG_POST: n.post = reg_wdata[CNT_W-1:0];
                acq_timing_pkg::REG_PRE: n.pre = reg_wdata[CNT_W-1:0];
                acq_timing_pkg::REG_DIV: n.div = reg_wdata[CNT_W-1:0];
                acq_timing_pkg::REG_DELAY: n.dly = reg_wdata[CNT_W-1:0];
                acq_timing_pkg::REG_SRC:
                    n.src = reg_wdata[acq_timing_pkg::SRC_W-1:0];
                acq_timing_pkg::REG_IRQ_STAT:
                    n.stat = s.stat & ~reg_wdata[acq_timing_pkg::IRQ_W-1:0];
                acq_timing_pkg::REG_IRQ_MASK:
                    n.mask = reg_wdata[acq_timing_pkg::IRQ_W-1:0];
                default: n.mask = s.mask;
            endcase
        end
        // Set wins over a clear in the same cycle
        n.stat = n.stat | ev;
        n.irq = |(n.stat & n.mask);

        // ------------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------------
        if (reg_rd) begin
            case (reg_addr)
                acq_timing_pkg::REG_CTRL:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.ctrl);
                acq_timing_pkg::REG_POST:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.post);
                acq_timing_pkg::REG_PRE:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.pre);
                acq_timing_pkg::REG_DIV:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.div);
                acq_timing_pkg::REG_DELAY:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.dly);
                acq_timing_pkg::REG_SRC:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.src);
                acq_timing_pkg::REG_STATUS:
                    n.rd_data = acq_timing_pkg::DATA_W'({s.buf_full,
                                                         s.state});
                acq_timing_pkg::REG_IRQ_STAT:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.stat);
                acq_timing_pkg::REG_IRQ_MASK:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.mask);
                acq_timing_pkg::REG_COUNT:
                    n.rd_data = acq_timing_pkg::DATA_W'(s.cnt);
                default: n.rd_data = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.ctrl <= acq_timing_pkg::CTRL_RST;
            s.src <= acq_timing_pkg::SRC_RST;
            s.div <= acq_timing_pkg::DIV_RST[CNT_W-1:0];
            s.dly <= acq_timing_pkg::DELAY_RST[CNT_W-1:0];
            s.post <= acq_timing_pkg::COUNT_RST[CNT_W-1:0];
            s.pre <= acq_timing_pkg::COUNT_RST[CNT_W-1:0];
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rd_data;
    assign strobe_out_pin_o = s.pin_o;
    assign strobe_out_pin_oe = s.ctrl[acq_timing_pkg::C_PIN_OUT];
    assign begin_trigger_out_line = s.begin_out;
    assign begin_trigger_out_oe = s.ctrl[acq_timing_pkg::C_BEGIN_OUT];
    assign acq_capture = s.capture;
    assign buf_wr_addr = s.wr_ptr;
    assign buf_overwrite = s.overwrite;
    assign irq = s.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence post_start_s;
        start && !s.ctrl[acq_timing_pkg::C_CONT] &&
        !s.ctrl[acq_timing_pkg::C_PRETRIG];
    endsequence
    sequence last_post_s;
        s.state == ST_POST && strobe && s.cnt <= CNT_W'(1);
    endsequence
    sequence last_pre_s;
        s.state == ST_PRE && strobe && s.cnt <= CNT_W'(1);
    endsequence

    post_load_a: assert property (
        post_start_s |=> s.state == ST_POST && s.cnt == $past(s.post))
        else $error("posttrigger count not loaded");
    pre_reload_a: assert property (
        last_pre_s ##0 !sw_stop
        |=> s.state == ST_WAIT_REF && s.cnt == $past(s.post))
        else $error("posttrigger count not reloaded");
    ref_ignored_a: assert property (
        s.state == ST_PRE && ref_evt && !sw_stop &&
        !(strobe && s.cnt <= CNT_W'(1))
        |=> s.state == ST_PRE && s.stat[acq_timing_pkg::IRQ_REF_IGN])
        else $error("early reference trigger not ignored");
    post_count_a: assert property (
        s.state == ST_POST && strobe && s.cnt > CNT_W'(1) && !sw_stop
        |=> s.cnt == $past(s.cnt) - CNT_W'(1))
        else $error("posttrigger count did not step");
    sw_begin_pulse_a: assert property (
        start && s.ctrl[acq_timing_pkg::C_BEGIN_SW]
        |=> begin_trigger_out_line ##1 !begin_trigger_out_line)
        else $error("software start pulse missing");
    capture_once_a: assert property (
        strobe |=> acq_capture && strobe_out_pin_o)
        else $error("strobe did not capture");
    pin_dir_a: assert property (
        $rose(strobe_out_pin_oe) |->
        $past(reg_wr) && $past(reg_addr) == acq_timing_pkg::REG_CTRL)
        else $error("strobe pin made output without a write");
    stop_idle_a: assert property (
        sw_stop && active |=> s.state == ST_IDLE ##1 !acq_capture)
        else $error("stop command ignored");
    done_flag_a: assert property (
        last_post_s |=> s.state == ST_IDLE &&
        s.stat[acq_timing_pkg::IRQ_DONE])
        else $error("completion flag not raised");
endmodule // acq_timing

// file: trig_source.sv
// Purpose: External trigger and strobe source on function and bus lines
// Assumes: One pulse at a time, launched by fire for one cycle
// Notes:   Lines idle low; a pulse stays high for three cycles
`timescale 1ns/10ps
module trig_source #(
    parameter int N_PFI = 10
) (
    // Clock
    input wire logic clk_sys,
    // Request
    input wire logic fire,
    input wire logic [4:0] sel,
    // Lines
    output logic [N_PFI-1:0] programmable_function_line,
    output logic [6:0] bus_trigger_line
);
    logic [N_PFI+6:0] lines_r = '0;
    int hold = 0;
    // Source supplies each edge itself
    always @(posedge clk_sys) begin
        if (fire) begin
            lines_r <= (N_PFI+7)'(1) << sel;
            hold <= 3;
        end else if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            lines_r <= '0;
            hold <= 0;
        end
    end
    assign programmable_function_line = lines_r[N_PFI-1:0];
    assign bus_trigger_line = lines_r[N_PFI+6:N_PFI];
endmodule // trig_source

// file: acq_trigger_sample_timing_test.sv
// Purpose: Self-checking bench for the acquisition timing engine
// Assumes: Register port and trigger lines driven at rising edges
// Notes:   Expected counts kept as integers in the bench
`timescale 1ns/10ps
module acq_trigger_sample_timing_test;
    logic clk_sys = 0, nrst = 0, reg_wr, reg_rd, fire, pin_i;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [4:0] sel;
    logic [9:0] pfl;
    logic [6:0] btl;
    logic pin_o, pin_oe, beg_o, beg_oe, acq_capture, ovw, irq;
    logic [23:0] wr_addr;
    int n_fail = 0, check_count = 0, cyc = 0, n_cap, n_pin, n_beg;
    int t_beg, t_cap, got, k, po, pr, n0, dly [2];
    int n_ovw = 0, mp = 0, bsz = 1;
    int seed = 32'he4cefb13;

    always #20 clk_sys = ~clk_sys;

    acq_timing u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .programmable_function_line(pfl),
        .bus_trigger_line(btl), .strobe_out_pin_i(pin_i),
        .strobe_out_pin_o(pin_o), .strobe_out_pin_oe(pin_oe),
        .begin_trigger_out_line(beg_o), .begin_trigger_out_oe(beg_oe),
        .acq_capture(acq_capture), .buf_wr_addr(wr_addr),
        .buf_overwrite(ovw), .irq(irq));
    trig_source u_src (.clk_sys(clk_sys), .fire(fire), .sel(sel),
        .programmable_function_line(pfl), .bus_trigger_line(btl));

    // -------------------------------------------------------------------
    // Event counters and timeout
    // -------------------------------------------------------------------
    always @(negedge clk_sys) begin
        cyc++;
        if (acq_capture === 1'b1) begin
            n_cap++;
            mp = (mp + 1) % bsz;
            check(32'(wr_addr), mp, "buffer pointer");
        end
        if (ovw === 1'b1) n_ovw++;
        if (acq_capture === 1'b1 && got == 0) begin
            t_cap = cyc;
            got = 1;
        end
        if (pin_o === 1'b1) n_pin++;
        if (beg_o === 1'b1) begin
            n_beg++;
            t_beg = cyc;
        end
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pulse(input logic [4:0] s);
        @(posedge clk_sys);
        fire <= 1'b1;
        sel <= s;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (7) @(posedge clk_sys);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_sys);
        check(32'(irq), 32'h1, "irq");
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 0;
        reg_rd = 0;
        fire = 0;
        sel = 5'h0;
        pin_i = 0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(acq_timing_pkg::REG_CTRL, v);
        check(v, 32'h4, "ctrl");
        rd(acq_timing_pkg::REG_DIV, v);
        check(v, 32'h2, "div");
        rd(acq_timing_pkg::REG_DELAY, v);
        check(v, 32'h2, "dly");
        rd(acq_timing_pkg::REG_SRC, v);
        check(v, 32'h0, "src");
        check(32'(pin_oe), 32'h0, "pin dir");
        rd(4'hb, v);
        check(v, 32'h0, "unmapped");
        wr(acq_timing_pkg::REG_IRQ_MASK, 32'h1);
        // Posttrigger runs, software start, two first-strobe delays
        for (k = 0; k < 2; k++) begin
            po = 1 + ($random(seed) & 3);
            wr(acq_timing_pkg::REG_CTRL, 32'h1084);
            wr(acq_timing_pkg::REG_POST, po);
            wr(acq_timing_pkg::REG_DELAY, k * 3 + 2);
            check(32'({beg_oe, pin_oe}), 32'h3, "out dir");
            n_cap = 0;
            n_pin = 0;
            n_beg = 0;
            got = 0;
            mp = 0;
            bsz = po;
            wr(acq_timing_pkg::REG_CMD, 32'h1);
            wait_irq();
            check(n_cap, po, "captures");
            check(n_pin, po, "pin pulses");
            check(n_beg, 1, "start pulse");
            dly[k] = t_cap - t_beg;
            wr(acq_timing_pkg::REG_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk_sys);
            #1 check(32'(irq), 32'h0, "irq clear");
        end
        check(dly[1] - dly[0], 3, "delay step");
        // Pretrigger, strobe on a function line, reference on a bus line
        pr = 2 + ($random(seed) & 1);
        po = 1 + ($random(seed) & 3);
        wr(acq_timing_pkg::REG_SRC, 32'h3003);
        wr(acq_timing_pkg::REG_PRE, pr);
        wr(acq_timing_pkg::REG_POST, po);
        wr(acq_timing_pkg::REG_CTRL, 32'h825);
        n_cap = 0;
        n_ovw = 0;
        mp = 0;
        bsz = pr + po;
        wr(acq_timing_pkg::REG_CMD, 32'h1);
        pulse(5'd3);
        pulse(5'd12);
        rd(acq_timing_pkg::REG_IRQ_STAT, v);
        check(v & 7, 32'h4, "early");
        wr(acq_timing_pkg::REG_IRQ_STAT, 32'h4);
        // Past the pretrigger count, then fill the buffer and wrap once
        for (k = 0; k < pr + po; k++) pulse(5'd3);
        rd(acq_timing_pkg::REG_STATUS, v);
        check(v & 15, 32'ha, "wait full");
        check(n_ovw, 1, "overwrite");
        pulse(5'd12);
        n0 = n_cap;
        for (k = 0; k < po; k++) pulse(5'd3);
        wait_irq();
        check(n_cap - n0, po, "post after ref");
        check(n_cap, pr + 2 * po + 1, "total");
        rd(acq_timing_pkg::REG_IRQ_STAT, v);
        check(v & 7, 32'h3, "ref");
        // Hardware start and external timebase ticks on falling edges
        wr(acq_timing_pkg::REG_IRQ_STAT, 32'h7);
        wr(acq_timing_pkg::REG_SRC, 32'h200a0);
        wr(acq_timing_pkg::REG_CTRL, 32'h350);
        n_cap = 0;
        n_beg = 0;
        mp = 0;
        bsz = po;
        pulse(5'd5);
        rd(acq_timing_pkg::REG_STATUS, v);
        check(v & 7, 32'h3, "line start");
        @(posedge clk_sys);
        fire <= 1'b1;
        sel <= 5'd4;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(n_cap, 0, "tick rise");
        repeat (4) @(posedge clk_sys);
        check(n_cap, 1, "tick fall");
        for (k = 1; k < po; k++) pulse(5'd4);
        wait_irq();
        check(n_cap, po, "tick captures");
        check(n_beg, 0, "no start pulse");
        // Continuous run on timebase ticks, ended by stop
        wr(acq_timing_pkg::REG_CTRL, 32'h46);
        wr(acq_timing_pkg::REG_IRQ_STAT, 32'h7);
        mp = 0;
        wr(acq_timing_pkg::REG_CMD, 32'h1);
        repeat (10) @(posedge clk_sys);
        rd(acq_timing_pkg::REG_STATUS, v);
        check(v & 7, 32'h4, "cont");
        wr(acq_timing_pkg::REG_CMD, 32'h2);
        repeat (3) @(posedge clk_sys);
        n0 = n_cap;
        repeat (10) @(posedge clk_sys);
        check(n_cap, n0, "stopped");
        rd(acq_timing_pkg::REG_STATUS, v);
        check(v & 7, 32'h0, "idle");
        complete_run();
    end
endmodule // acq_trigger_sample_timing_test
